// ==== design/mswca_pkg.sv ====
package mswca_pkg;
  localparam int HALF_W       = 32;
  localparam int KEEP_HALF_W  = 4;
  localparam int TX_W         = 73;
  localparam int RX_W         = 74;
  localparam int LAST_BIT     = 72;
  localparam int KEEP_LSB     = 64;
  localparam int KEEP_HI_LSB  = 68;
  localparam int ERR_BIT      = 73;
  localparam int TX_AW        = 8;
  localparam int MK_AW        = 4;
  localparam int RX_AW        = 8;
  localparam int DROP_W       = 16;

  // free-space limits; rx keeps headroom for the two-stage write pipeline
  localparam logic [TX_AW:0] TX_LIMIT  = 9'h0fe;
  localparam logic [MK_AW:0] MK_LIMIT  = 5'h0f;
  localparam logic [RX_AW:0] RX_LIMIT  = 9'h0fc;
  localparam logic [MK_AW:0] RMK_LIMIT = 5'h0d;

  localparam logic [1:0] RX_GAP_LAST = 2'h0;

  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DROPS  = 4'h8;
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  typedef struct packed {
    logic [63:0] word;
    logic [7:0]  keep;
    logic        last;
  } mswca_usr_s;

  typedef struct packed {
    logic [31:0] word;
    logic [3:0]  keep;
    logic        last;
  } mswca_lnk_s;
endpackage : mswca_pkg

// ==== design/mswca_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
// first-word-fall-through fifo, flip-flop storage
module mswca_fifo #(
  parameter int W  = 73,
  parameter int AW = 4
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_wr_en,
  input  wire logic [W-1:0]  i_wr_word,
  output logic      [AW:0]   o_wr_count,
  input  wire logic          i_rd_ack,
  output logic      [W-1:0]  o_rd_word,
  output logic               o_empty
);
  typedef struct packed {
    logic [(1<<AW)-1:0][W-1:0] mem;
    logic [AW:0]               wr_ptr;
    logic [AW:0]               rd_ptr;
  } mswca_fifo_s;

  mswca_fifo_s s_q;
  mswca_fifo_s s_d;
  logic        full;

  assign o_wr_count = s_q.wr_ptr - s_q.rd_ptr;
  assign o_empty    = (s_q.wr_ptr == s_q.rd_ptr);
  assign full       = (o_wr_count[AW] == 1'b1);
  assign o_rd_word  = s_q.mem[s_q.rd_ptr[AW-1:0]];

  always_comb begin
    s_d = s_q;
    // writes into a full fifo and reads from an empty one are dropped
    if (i_wr_en && !full) begin
      s_d.mem[s_q.wr_ptr[AW-1:0]] = i_wr_word;
      s_d.wr_ptr = s_q.wr_ptr + 1'b1;
    end
    if (i_rd_ack && !o_empty) begin
      s_d.rd_ptr = s_q.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      s_q.wr_ptr <= '0;
      s_q.rd_ptr <= '0;
      s_q.mem    <= s_d.mem;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : mswca_fifo
`default_nettype wire

// ==== design/mswca_adapter.sv ====
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - user ready drops when tx data or marker fifo lacks space.
// - storing a packet's last word writes one marker entry.
// - first read needs first-read flag, both fifos filled, link idle or last taken.
// - each 64-bit word leaves as two 32-bit beats, lower half first; a last word with bit 68 clear leaves as one.
// - lower beat taken loads held upper half and its last, sets upper flag.
// - read ack loads low half out, holds high half; lasts from bits 72, 68.
// - later reads need data present and the upper beat accepted.
// - first-read flag clears on first word, sets again on last word.
// - reading the last word pulses marker read ack one cycle.
// - link valid is set-reset: set after first read, cleared after last beat.
// - link ready low stops reads while link valid is high and holds output beat steady.
// - single-beat packet: last on first beat, first-read flag stays set.
// - rx fifo near full mid-packet: write last+error entry, drop the rest.
// - after a drop, writing resumes on a new packet with space in both.
// - two 32-bit beats form one rx write; lone lower beat is padded.
// - rx marker written when rx write enable and bit 72 are high.
// - rx reading starts with a whole packet stored, runs until bit 72.
// - two idle read cycles follow each packet's last word.
// - user output stream holds valid high through each packet; it has no ready.
// - first rx beat goes to bits 31..0/67..64, second to 63..32/71..68.
// - a lone lower beat clears the four upper keep bits.
module mswca_adapter (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_sys_rst,
  input  wire logic [3:0]           i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire logic [31:0]          i_avs_writedata,
  output logic      [31:0]          o_avs_readdata,
  output logic                      o_avs_waitrequest,
  input  wire logic                 i_user_in_valid,
  input  wire mswca_pkg::mswca_usr_s i_user_in,
  output logic                      o_user_in_ready,
  output logic                      o_link_out_valid,
  output mswca_pkg::mswca_lnk_s     o_link_out,
  input  wire logic                 i_link_out_ready,
  input  wire logic                 i_link_in_valid,
  input  wire mswca_pkg::mswca_lnk_s i_link_in,
  output logic                      o_user_out_valid,
  output mswca_pkg::mswca_usr_s     o_user_out,
  output logic                      o_user_out_error
);
  typedef enum logic [1:0] {RD_IDLE, RD_BURST, RD_GAP} mswca_rd_e;

  typedef struct packed {
    logic                first_read;
    logic                upper_half;
    logic                out_valid;
    mswca_pkg::mswca_lnk_s out_beat;
    mswca_pkg::mswca_lnk_s hold_beat;
    logic                in_v;
    mswca_pkg::mswca_lnk_s in_beat;
    logic                discarding;
    logic                in_pkt;
    logic                word_hi;
    logic                wr_en;
    logic [73:0]         wr_word;
    mswca_rd_e           rd_state;
    logic [1:0]          gap_cnt;
    logic                rd_ack;
    logic [1:0]          ctrl;
    logic [15:0]         drops;
    logic                av_ack;
    logic [31:0]         rdata;
  } mswca_state_s;

  mswca_state_s s_q;
  mswca_state_s s_d;

  logic [72:0] tx_rd_word;
  logic [8:0]  tx_count;
  logic [4:0]  mk_count;
  logic        tx_empty;
  logic        mk_empty;
  logic        tx_wr;
  logic        mk_wr;
  logic        tx_rd_ack;
  logic        mk_rd_ack;
  logic        start_ok;
  logic        cont_ok;
  logic        last_done;
  logic        beat_done;
  logic [73:0] rx_rd_word;
  logic [8:0]  rx_count;
  logic [4:0]  rmk_count;
  logic        rx_empty;
  logic        rmk_empty;
  logic        rmk_wr;
  logic        rmk_rd_ack;
  logic        rx_afull;
  logic        av_req;

  // tx write side
  assign o_user_in_ready = s_q.ctrl[mswca_pkg::CTRL_TX_EN]
                           && (tx_count < mswca_pkg::TX_LIMIT)
                           && (mk_count < mswca_pkg::MK_LIMIT);
  assign tx_wr = i_user_in_valid && o_user_in_ready;
  assign mk_wr = tx_wr && i_user_in.last;

  mswca_fifo #(.W(mswca_pkg::TX_W), .AW(mswca_pkg::TX_AW)) u_tx_data_fifo (
    .i_ref_clk  (i_ref_clk),
    .i_sys_rst  (i_sys_rst),
    .i_wr_en    (tx_wr),
    .i_wr_word  ({i_user_in.last, i_user_in.keep, i_user_in.word}),
    .o_wr_count (tx_count),
    .i_rd_ack   (tx_rd_ack),
    .o_rd_word  (tx_rd_word),
    .o_empty    (tx_empty)
  );

  mswca_fifo #(.W(1), .AW(mswca_pkg::MK_AW)) u_tx_marker_fifo (
    .i_ref_clk  (i_ref_clk),
    .i_sys_rst  (i_sys_rst),
    .i_wr_en    (mk_wr),
    .i_wr_word  (1'b1),
    .o_wr_count (mk_count),
    .i_rd_ack   (mk_rd_ack),
    .o_rd_word  (),
    .o_empty    (mk_empty)
  );

  // tx read side
  assign beat_done = s_q.out_valid && i_link_out_ready;
  assign last_done = beat_done && s_q.out_beat.last;
  assign start_ok  = s_q.first_read && !tx_empty && !mk_empty
                     && (!s_q.out_valid || last_done);
  assign cont_ok   = !s_q.first_read && !tx_empty && s_q.out_valid
                     && i_link_out_ready && s_q.upper_half;
  assign tx_rd_ack = start_ok || cont_ok;
  assign mk_rd_ack = tx_rd_ack && tx_rd_word[mswca_pkg::LAST_BIT];

  assign o_link_out_valid = s_q.out_valid;
  assign o_link_out       = s_q.out_beat;

  // rx side
  mswca_fifo #(.W(mswca_pkg::RX_W), .AW(mswca_pkg::RX_AW)) u_rx_data_fifo (
    .i_ref_clk  (i_ref_clk),
    .i_sys_rst  (i_sys_rst),
    .i_wr_en    (s_q.wr_en),
    .i_wr_word  (s_q.wr_word),
    .o_wr_count (rx_count),
    .i_rd_ack   (s_q.rd_ack),
    .o_rd_word  (rx_rd_word),
    .o_empty    (rx_empty)
  );

  assign rmk_wr = s_q.wr_en && s_q.wr_word[mswca_pkg::LAST_BIT];
  assign rmk_rd_ack = s_q.rd_ack && rx_rd_word[mswca_pkg::LAST_BIT];

  mswca_fifo #(.W(1), .AW(mswca_pkg::MK_AW)) u_rx_marker_fifo (
    .i_ref_clk  (i_ref_clk),
    .i_sys_rst  (i_sys_rst),
    .i_wr_en    (rmk_wr),
    .i_wr_word  (1'b1),
    .o_wr_count (rmk_count),
    .i_rd_ack   (rmk_rd_ack),
    .o_rd_word  (),
    .o_empty    (rmk_empty)
  );

  assign rx_afull = (rx_count >= mswca_pkg::RX_LIMIT)
                    || (rmk_count >= mswca_pkg::RMK_LIMIT);

  // consumer never stalls, so valid is the read ack itself
  assign o_user_out_valid = s_q.rd_ack;
  assign o_user_out.word  = rx_rd_word[63:0];
  assign o_user_out.keep  = rx_rd_word[71:64];
  assign o_user_out.last  = rx_rd_word[mswca_pkg::LAST_BIT];
  assign o_user_out_error = rx_rd_word[mswca_pkg::ERR_BIT];

  // register bus: one wait cycle, then the answer
  assign av_req            = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = av_req && !s_q.av_ack;
  assign o_avs_readdata    = s_q.rdata;

  always_comb begin
    logic trunc;
    logic eff_last;
    logic take;
    trunc    = 1'b0;
    eff_last = 1'b0;
    take     = 1'b0;
    s_d = s_q;

    // tx read and split
    if (tx_rd_ack) begin
      s_d.out_beat.word  = tx_rd_word[31:0];
      s_d.out_beat.keep  = tx_rd_word[67:64];
      s_d.out_beat.last  = tx_rd_word[mswca_pkg::LAST_BIT]
                           && !tx_rd_word[mswca_pkg::KEEP_HI_LSB];
      s_d.hold_beat.word = tx_rd_word[63:32];
      s_d.hold_beat.keep = tx_rd_word[71:68];
      s_d.hold_beat.last = tx_rd_word[mswca_pkg::LAST_BIT]
                           && tx_rd_word[mswca_pkg::KEEP_HI_LSB];
      s_d.upper_half = 1'b0;
      s_d.out_valid  = 1'b1;
      s_d.first_read = tx_rd_word[mswca_pkg::LAST_BIT];
    end else if (beat_done && !s_q.upper_half && !s_q.out_beat.last) begin
      s_d.out_beat   = s_q.hold_beat;
      s_d.upper_half = 1'b1;
    end else if (beat_done) begin
      s_d.out_valid = 1'b0;
    end

    // rx input stage and error detection
    s_d.in_v    = i_link_in_valid;
    s_d.in_beat = i_link_in;
    s_d.wr_en   = 1'b0;
    if (s_q.in_v) begin
      if (s_q.discarding) begin
        s_d.discarding = !s_q.in_beat.last;
      end else if (!s_q.in_pkt && (rx_afull || !s_q.ctrl[mswca_pkg::CTRL_RX_EN])) begin
        // no room or rx disabled at packet start: drop it whole, nothing is written
        s_d.discarding = !s_q.in_beat.last;
        s_d.drops      = s_q.drops + 1'b1;
      end else begin
        take     = 1'b1;
        trunc    = s_q.in_pkt && rx_afull && !s_q.in_beat.last;
        eff_last = s_q.in_beat.last || trunc;
        s_d.in_pkt     = !eff_last;
        s_d.discarding = trunc;
        if (trunc) begin
          s_d.drops = s_q.drops + 1'b1;
        end
      end
    end

    // rx write controller
    if (take) begin
      if (!s_q.word_hi) begin
        s_d.wr_word[31:0]  = s_q.in_beat.word;
        s_d.wr_word[67:64] = s_q.in_beat.keep;
        if (eff_last) begin
          s_d.wr_word[63:32] = '0;
          s_d.wr_word[71:68] = '0;
          s_d.wr_word[mswca_pkg::LAST_BIT] = 1'b1;
          s_d.wr_word[mswca_pkg::ERR_BIT]  = trunc;
          s_d.wr_en = 1'b1;
        end else begin
          s_d.word_hi = 1'b1;
        end
      end else begin
        s_d.wr_word[63:32] = s_q.in_beat.word;
        s_d.wr_word[71:68] = s_q.in_beat.keep;
        s_d.wr_word[mswca_pkg::LAST_BIT] = eff_last;
        s_d.wr_word[mswca_pkg::ERR_BIT]  = trunc;
        s_d.wr_en   = 1'b1;
        s_d.word_hi = 1'b0;
      end
    end

    // rx read sequencing
    unique case (s_q.rd_state)
      RD_IDLE: begin
        if (!rx_empty && !rmk_empty) begin
          s_d.rd_ack   = 1'b1;
          s_d.rd_state = RD_BURST;
        end
      end
      RD_BURST: begin
        if (rx_rd_word[mswca_pkg::LAST_BIT]) begin
          s_d.rd_ack   = 1'b0;
          s_d.gap_cnt  = '0;
          s_d.rd_state = RD_GAP;
        end
      end
      RD_GAP: begin
        // gap state plus one idle decision cycle gives the two quiet cycles
        if (s_q.gap_cnt == mswca_pkg::RX_GAP_LAST) begin
          s_d.rd_state = RD_IDLE;
        end else begin
          s_d.gap_cnt = s_q.gap_cnt + 1'b1;
        end
      end
    endcase

    // register bus
    s_d.av_ack = av_req && !s_q.av_ack;
    if (av_req && !s_q.av_ack) begin
      unique case (i_avs_address)
        mswca_pkg::REG_CTRL:   s_d.rdata = {30'h0, s_q.ctrl};
        mswca_pkg::REG_STATUS: s_d.rdata = {27'h0, s_q.out_valid, s_q.discarding,
                                            rx_empty, mk_empty, tx_empty};
        mswca_pkg::REG_DROPS:  s_d.rdata = {16'h0, s_q.drops};
        default:               s_d.rdata = '0;
      endcase
    end
    if (i_avs_write && s_q.av_ack) begin
      if (i_avs_address == mswca_pkg::REG_CTRL) begin
        s_d.ctrl = i_avs_writedata[1:0];
      end else if (i_avs_address == mswca_pkg::REG_DROPS && s_d.drops == s_q.drops) begin
        // a drop counted in the same cycle wins over the clear
        s_d.drops = '0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      s_q            <= '0;
      s_q.first_read <= 1'b1;
      s_q.rd_state   <= RD_IDLE;
      s_q.ctrl       <= mswca_pkg::CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : mswca_adapter
`default_nettype wire

// ==== bench/mswca_adapter_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module mswca_adapter_checker (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic                  o_avs_waitrequest,
  input  wire logic                  o_link_out_valid,
  input  wire mswca_pkg::mswca_lnk_s o_link_out,
  input  wire logic                  i_link_out_ready,
  input  wire logic                  o_user_out_valid,
  input  wire mswca_pkg::mswca_usr_s o_user_out,
  input  wire logic                  o_user_out_error
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  chk_stall_hold: assert property (
    o_link_out_valid && !i_link_out_ready |=> $stable(o_link_out))
    else $error("link beat changed while stalled");
  chk_pkt_valid: assert property (
    o_link_out_valid && !(i_link_out_ready && o_link_out.last) |=> o_link_out_valid)
    else $error("link valid dropped inside packet");
  chk_pkt_end: assert property (
    o_link_out_valid && i_link_out_ready && o_link_out.last
      |=> !o_link_out_valid || !$stable(o_link_out))
    else $error("last beat repeated after acceptance");
  chk_rx_burst: assert property (
    o_user_out_valid && !o_user_out.last |=> o_user_out_valid)
    else $error("gap inside user packet");
  chk_rx_gap: assert property (
    o_user_out_valid && o_user_out.last |=> !o_user_out_valid [*2])
    else $error("no two-cycle pause after packet");
  chk_err_last: assert property (
    o_user_out_valid && o_user_out_error |-> o_user_out.last)
    else $error("error word without last");
  chk_pad_zero: assert property (
    o_user_out_valid && o_user_out.keep[7:4] == 4'h0 |-> o_user_out.word[63:32] == 32'h0)
    else $error("padded upper half not zero");
  chk_bus_wait: assert property (
    $rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("register answer not after one wait cycle");
  cover property (o_link_out_valid && !i_link_out_ready);
  cover property (o_user_out_valid && o_user_out.last);
  cover property (o_link_out_valid && o_link_out.last && !o_link_out.keep[0] == 1'b0);
endmodule : mswca_adapter_checker
bind mswca_adapter mswca_adapter_checker u_chk (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .o_link_out_valid(o_link_out_valid), .o_link_out(o_link_out),
  .i_link_out_ready(i_link_out_ready), .o_user_out_valid(o_user_out_valid),
  .o_user_out(o_user_out), .o_user_out_error(o_user_out_error));
`default_nettype wire

// ==== bench/mswca_mac_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module mswca_mac_model (
  input  wire logic             i_ref_clk,
  output logic                  o_link_out_ready,
  output logic                  o_link_in_valid,
  output mswca_pkg::mswca_lnk_s o_link_in
);
  logic [73:0] exp_q[$];
  bit          stall = 1'b0;
  initial begin
    o_link_out_ready = 1'b1;
    o_link_in_valid = 1'b0;
    o_link_in = '0;
  end
  // a real mac may pause acceptance on any beat
  always @(posedge i_ref_clk) o_link_out_ready <= stall ? ($urandom % 3 != 0) : 1'b1;
  task automatic send_pkt(input int n);
    logic [31:0] b[$];
    logic [31:0] d;
    for (int i = 0; i < n; i++) begin
      d = $urandom;
      b.push_back(d);
      @(posedge i_ref_clk);
      o_link_in_valid <= 1'b1;
      o_link_in <= '{word: d, keep: 4'hf, last: (i == n - 1)};
    end
    for (int i = 0; i < n; i += 2)
      exp_q.push_back({1'b0, (i + 1 < n ? b[i + 1] : 32'h0), b[i],
                       (i + 1 < n ? 8'hff : 8'h0f), (i + 2 >= n)});
    @(posedge i_ref_clk);
    o_link_in_valid <= 1'b0;
    // released lines must not keep showing the last beat
    o_link_in <= ~o_link_in;
    repeat (3) @(posedge i_ref_clk);
  endtask : send_pkt
endmodule : mswca_mac_model
`default_nettype wire

// ==== bench/test_mswca_adapter.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_mswca_adapter;
  logic                  i_ref_clk = 1'b0;
  logic                  i_sys_rst = 1'b1;
  logic [3:0]            avs_addr = 4'h0;
  logic                  avs_rd = 1'b0;
  logic                  avs_wr = 1'b0;
  logic [31:0]           avs_wd = 32'h0;
  logic [31:0]           avs_rdata;
  logic                  avs_wait;
  logic                  uin_valid = 1'b0;
  mswca_pkg::mswca_usr_s uin = '0;
  logic                  uin_ready, lout_valid, lout_ready, lin_valid, uout_valid, uout_err;
  mswca_pkg::mswca_lnk_s lout, lin;
  mswca_pkg::mswca_usr_s uout;
  int                    err_count = 0;
  int                    comparisons = 0;
  int                    cycles = 0;
  logic [36:0]           exp_lnk[$];
  logic [31:0]           exp_reg[$];

  initial forever #5 i_ref_clk = ~i_ref_clk;

  mswca_adapter dut (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_avs_address(avs_addr),
    .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(avs_wd),
    .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait),
    .i_user_in_valid(uin_valid), .i_user_in(uin), .o_user_in_ready(uin_ready),
    .o_link_out_valid(lout_valid), .o_link_out(lout), .i_link_out_ready(lout_ready),
    .i_link_in_valid(lin_valid), .i_link_in(lin), .o_user_out_valid(uout_valid),
    .o_user_out(uout), .o_user_out_error(uout_err));

  mswca_mac_model mac (
    .i_ref_clk(i_ref_clk), .o_link_out_ready(lout_ready),
    .o_link_in_valid(lin_valid), .o_link_in(lin));

  task automatic note(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : note

  task automatic cmp_lnk(input logic [36:0] got);
    note(exp_lnk.size() != 0 && got === exp_lnk.pop_front(), "link beat mismatch");
  endtask : cmp_lnk

  task automatic cmp_usr(input logic [73:0] got);
    note(mac.exp_q.size() != 0 && got === mac.exp_q.pop_front(), "user word mismatch");
  endtask : cmp_usr

  task automatic cmp_reg(input logic [31:0] got);
    note(exp_reg.size() != 0 && got === exp_reg.pop_front(), "register value mismatch");
  endtask : cmp_reg

  task automatic test_done();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // results are checked where they appear, against notes left by the drivers
  always @(posedge i_ref_clk) begin
    if (lout_valid && lout_ready) cmp_lnk(lout);
    if (uout_valid) cmp_usr({uout_err, uout});
    if (avs_rd && !avs_wait) cmp_reg(avs_rdata);
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic avs(input bit wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    avs_rd <= !wr;
    avs_wr <= wr;
    avs_addr <= a;
    avs_wd <= d;
    do @(posedge i_ref_clk); while (avs_wait !== 1'b0);
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
  endtask : avs

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_reg.push_back(e);
    avs(1'b0, a, 32'h0);
  endtask : rd

  // odd-length packets end on a lone lower beat
  task automatic send_tx(input int n);
    mswca_pkg::mswca_usr_s w;
    @(posedge i_ref_clk);
    for (int i = 0; i < n; i++) begin
      w.word = {$urandom, $urandom};
      w.last = (i == n - 1);
      w.keep = (w.last && n % 2) ? 8'h0f : 8'hff;
      exp_lnk.push_back({w.word[31:0], w.keep[3:0], w.last && !w.keep[4]});
      if (w.keep[4]) exp_lnk.push_back({w.word[63:32], w.keep[7:4], w.last});
      uin_valid <= 1'b1;
      uin <= w;
      do @(posedge i_ref_clk); while (uin_ready !== 1'b1);
    end
    uin_valid <= 1'b0;
  endtask : send_tx

  initial begin
    void'($urandom(32'h8650));
    repeat (16) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    rd(4'h0, 32'h3);
    rd(4'h4, 32'h7);
    rd(4'h8, 32'h0);
    rd(4'hc, 32'h0);
    avs(1'b1, 4'hc, 32'hffff_ffff);
    rd(4'h0, 32'h3);
    for (int n = 1; n <= 6; n++) send_tx(n);
    mac.stall = 1'b1;
    for (int n = 1; n <= 6; n++) send_tx(n);
    for (int n = 1; n <= 7; n++) mac.send_pkt(n);
    repeat (300) @(posedge i_ref_clk);
    note(exp_lnk.size() == 0 && mac.exp_q.size() == 0, "results missing");
    rd(4'h8, 32'h0);
    // rx disabled: the whole packet is dropped, counted, and nothing reaches the user
    avs(1'b1, 4'h0, 32'h1);
    mac.send_pkt(3);
    mac.exp_q.delete();
    repeat (40) @(posedge i_ref_clk);
    rd(4'h8, 32'h1);
    avs(1'b1, 4'h8, 32'h0);
    rd(4'h8, 32'h0);
    avs(1'b1, 4'h0, 32'h3);
    rd(4'h0, 32'h3);
    @(posedge i_ref_clk);
    test_done();
  end
endmodule : test_mswca_adapter
`default_nettype wire
